// File: hdl/gpm_pin_cell.v
`timescale 1ns/1ns
`include "gpm_pin_mux_map.vh"

module gpm_pin_cell #(
    parameter IDLE0 = 1'b0
) (
    // general-purpose side
    input wire gpioOut,
    input wire gpioOe,
    output wire gpioIn,
    // function control
    input wire funcEn,
    input wire [1:0] funcSel,
    input wire [1:0] funcCount,
    // peripheral side, one bit per slot
    input wire [2:0] altOut,
    input wire [2:0] altOe,
    output wire [2:0] altIn,
    // pad side
    input wire padIn,
    output wire padOut,
    output wire padOe
);

wire present;
wire active;
wire [1:0] slot;

// out-of-range select falls back to the first slot rather than an undriven pad
assign slot = (funcSel < funcCount) ? funcSel : `GPM_SLOT_FIRST;
assign present = (funcCount != `GPM_NO_FUNC);
assign active = funcEn && present;

// peripheral replaces gpio data and direction when enabled
assign padOut = active ? altOut[slot] : (present & gpioOut);
assign padOe = active ? altOe[slot] : (present & gpioOe);
// gpio keeps seeing the raw pad level in either mode
assign gpioIn = present & padIn;

// only the selected peripheral sees the pad; others see their idle level
genvar k;
generate
    for (k = 0; k < `GPM_SLOTS; k = k + 1) begin : g_slot
        localparam [1:0] KS = k;
        localparam IDLE = (k == 0) ? IDLE0 : 1'b0;
        assign altIn[k] = (active && (slot == KS)) ? padIn : IDLE;
    end
endgenerate

endmodule

// File: hdl/gpm_pin_mux.v
`timescale 1ns/1ns
`include "gpm_pin_mux_map.vh"

// Functional notes
// - four ports A-D with 12, 11, 10 and 6 usable pins
// - port A resets to gpio except pin 7, which resets as reset input
// - port D pins 0-3 reset to test-port functions, pins 4-5 to gpio
// - all eleven port B pins (no bit 4) reset to gpio
// - A4/A5 select pulse output, timer 2/3, fault 1/2
// - A6 selects fault 0 or timer 0
// - A8/A9 select fault 1/2, timer 2/3, comparator A/B input 1
// - B0/B1 select serial clock/select or I2C clock/data
// - B2/B3 select serial data in/out, timer 2/3, pulse source 0/1
// - B5, B6 choices include clock input, gated by PLL clock-in enable
// - B7 selects serial transmit or I2C clock
// - B8/B9 select I2C clock/data or CAN transmit/receive
// - C0/C4 select converter input 0 or comparator input 3
// - C2,C3,C6,C7 select converter input or reference high/low input
// - D5 uses crystal select: crystal output or clock input; resets gpio
//
// slot map, global index = port base + bit, slot k of pin i is bit 3*i+k
//   A0..A3  : pulse out 0..3
//   A4      : pulse_out_4, timer_chan_2, fault_in_1
//   A5      : pulse_out_5, timer_chan_3, fault_in_2
//   A6      : fault_in_0, timer_chan_0
//   A7      : reset input (idle level 1 when not selected)
//   A8      : fault_in_1, timer_chan_2, comparator_a_input_1
//   A9      : fault_in_2, timer_chan_3, comparator_b_input_1
//   A10/A11 : comparator A/B input 2
//   B0      : serial_periph_clock, I2C clock
//   B1      : serial_periph_select, I2C data
//   B2      : serial_periph_data_in, timer_chan_2, pulse_source_in_0
//   B3      : serial_periph_data_out, timer_chan_3, pulse_source_in_1
//   B5      : timer_chan_1, fault_in_3, external_clock_input
//   B6      : serial_receive, I2C data, external_clock_input
//   B7      : serial_transmit, I2C clock
//   B8      : I2C clock, can_transmit_pin
//   B9      : I2C data, can_receive_pin
//   B10/B11 : comparator A/B output
//   C0      : converter_a_input_0, comparator_a_input_3
//   C1      : converter A input 1
//   C2/C3   : converter A input 2/3, converter_a_ref_high/low
//   C4      : converter_b_input_0, comparator_b_input_3
//   C5      : converter B input 1
//   C6/C7   : converter_b_input_2 / B input 3, converter B ref high/low
//   C8/C12  : converter A/B input 4
//   D0..D3  : test data in, test data out, test clock, test mode
//   D4      : crystal_input
//   D5      : crystal_output, external_clock_input

module gpm_pin_mux (
    // clock and reset
    input wire clk,
    input wire rst,
    // gpio data and direction from the port logic
    input wire [11:0] gpioAOut,
    input wire [11:0] gpioAOe,
    input wire [11:0] gpioBOut,
    input wire [11:0] gpioBOe,
    input wire [12:0] gpioCOut,
    input wire [12:0] gpioCOe,
    input wire [5:0] gpioDOut,
    input wire [5:0] gpioDOe,
    // pad levels seen by the port logic
    output wire [11:0] gpioAIn,
    output wire [11:0] gpioBIn,
    output wire [12:0] gpioCIn,
    output wire [5:0] gpioDIn,
    // peripheral slots, three per pin
    input wire [128:0] altOut,
    input wire [128:0] altOe,
    output reg [128:0] altIn,
    // pad pins
    input wire [11:0] padAIn,
    input wire [11:0] padBIn,
    input wire [12:0] padCIn,
    input wire [5:0] padDIn,
    output wire [11:0] padAOut,
    output wire [11:0] padAOe,
    output wire [11:0] padBOut,
    output wire [11:0] padBOe,
    output wire [12:0] padCOut,
    output wire [12:0] padCOe,
    output wire [5:0] padDOut,
    output wire [5:0] padDOe,
    // function enable bits, one per pin
    input wire funcEnWrite,
    input wire [42:0] funcEnData,
    output reg [42:0] funcEnState,
    // pin function select fields, two bits per pin
    input wire funcSelWrite,
    input wire [85:0] funcSelData,
    output reg [85:0] funcSelState,
    // crystal clock select for D5
    input wire crystalSelWrite,
    input wire crystalSelData,
    output reg crystalSelState,
    // clock-input enable from the PLL control
    input wire pllClockInEnable
);

localparam ALL = `GPM_ALL_PINS;
localparam SELW = `GPM_ALL_PINS * `GPM_SEL_W;
localparam ALTW = `GPM_ALL_PINS * `GPM_SLOTS;

// port widths and per-pin function sets, packed per port
localparam [23:0] CNT_A = `GPM_COUNT_A;
localparam [23:0] CNT_B = `GPM_COUNT_B;
localparam [25:0] CNT_C = `GPM_COUNT_C;
localparam [11:0] CNT_D = `GPM_COUNT_D;
localparam [SELW-1:0] COUNTS = {CNT_D, CNT_C, CNT_B, CNT_A};

// reset state of the function enables
localparam [42:0] EN_RST = {`GPM_EN_RST_D, `GPM_EN_RST_C, `GPM_EN_RST_B, `GPM_EN_RST_A};
localparam [ALTW-1:0] ONE = {{(ALTW-1){1'b0}}, 1'b1};
// the reset input slot idles high so an unselected pin never holds reset
localparam [ALTW-1:0] ALT_IN_RST = ONE << (`GPM_RESET_PIN * `GPM_SLOTS + `GPM_RESET_SLOT);
localparam [ALTW-1:0] CLOCK_IN_MASK = (ONE << (`GPM_CLOCK_IN_PIN_B5 * `GPM_SLOTS + `GPM_CLOCK_IN_SLOT)) |
                                      (ONE << (`GPM_CLOCK_IN_PIN_B6 * `GPM_SLOTS + `GPM_CLOCK_IN_SLOT));

// slot count of one pin; zero marks an absent bit
function [1:0] pinSlotCount;
    input integer idx;
    begin
        pinSlotCount = COUNTS[idx * `GPM_SEL_W +: `GPM_SEL_W];
    end
endfunction

////////////////////////////////////////////////////////////////////////////////

wire [ALL-1:0] allGpioOut;
wire [ALL-1:0] allGpioOe;
wire [ALL-1:0] allPadIn;
wire [ALL-1:0] presentMask;
wire [ALL-1:0] nextPadOut;
wire [ALL-1:0] nextPadOe;
wire [ALL-1:0] nextGpioIn;
wire [ALTW-1:0] cellAltIn;
wire [ALTW-1:0] next_altIn;
reg [ALL-1:0] padOutReg;
reg [ALL-1:0] padOeReg;
reg [ALL-1:0] gpioInReg;

// flatten the four ports into one pin vector
assign allGpioOut = {gpioDOut, gpioCOut, gpioBOut, gpioAOut};
assign allGpioOe = {gpioDOe, gpioCOe, gpioBOe, gpioAOe};
assign allPadIn = {padDIn, padCIn, padBIn, padAIn};

////////////////////////////////////////////////////////////////////////////////

// one mux cell per pin position
genvar i;
generate
    for (i = 0; i < ALL; i = i + 1) begin : g_pin
        wire [1:0] cnt;
        wire [1:0] sel;
        assign cnt = pinSlotCount(i);
        // D5 takes its choice from the crystal select, not the common field
        assign sel = (i == `GPM_CRYSTAL_PIN) ? {1'b0, crystalSelState} :
                     funcSelState[i * `GPM_SEL_W +: `GPM_SEL_W];
        assign presentMask[i] = (pinSlotCount(i) != `GPM_NO_FUNC);
        gpm_pin_cell #(
            .IDLE0((i == `GPM_RESET_PIN) ? 1'b1 : 1'b0)
        ) u_cell (
            .gpioOut(allGpioOut[i]),
            .gpioOe(allGpioOe[i]),
            .gpioIn(nextGpioIn[i]),
            .funcEn(funcEnState[i]),
            .funcSel(sel),
            .funcCount(cnt),
            .altOut(altOut[i * `GPM_SLOTS +: `GPM_SLOTS]),
            .altOe(altOe[i * `GPM_SLOTS +: `GPM_SLOTS]),
            .altIn(cellAltIn[i * `GPM_SLOTS +: `GPM_SLOTS]),
            .padIn(allPadIn[i]),
            .padOut(nextPadOut[i]),
            .padOe(nextPadOe[i])
        );
    end
endgenerate

// B5/B6 clock slot reaches the clock logic only once the PLL allows it
assign next_altIn = pllClockInEnable ? cellAltIn : (cellAltIn & ~CLOCK_IN_MASK);

////////////////////////////////////////////////////////////////////////////////

// configuration state; absent bits can never be enabled
always @(posedge clk) begin
    if (rst) begin
        funcEnState <= EN_RST;
        funcSelState <= {SELW{1'b0}};
        crystalSelState <= `GPM_CRYSTAL_RST;
    end else begin
        if (funcEnWrite) begin
            funcEnState <= funcEnData & presentMask;
        end
        if (funcSelWrite) begin
            funcSelState <= funcSelData;
        end
        if (crystalSelWrite) begin
            crystalSelState <= crystalSelData;
        end
    end
end

// registered pad and peripheral side; costs one cycle each way
always @(posedge clk) begin
    if (rst) begin
        padOutReg <= {ALL{1'b0}};
        padOeReg <= {ALL{1'b0}};
        gpioInReg <= {ALL{1'b0}};
        altIn <= ALT_IN_RST;
    end else begin
        padOutReg <= nextPadOut;
        padOeReg <= nextPadOe;
        gpioInReg <= nextGpioIn;
        altIn <= next_altIn;
    end
end

////////////////////////////////////////////////////////////////////////////////

// split back into ports
assign padAOut = padOutReg[`GPM_B_BASE-1:0];
assign padAOe = padOeReg[`GPM_B_BASE-1:0];
assign gpioAIn = gpioInReg[`GPM_B_BASE-1:0];
assign padBOut = padOutReg[`GPM_C_BASE-1:`GPM_B_BASE];
assign padBOe = padOeReg[`GPM_C_BASE-1:`GPM_B_BASE];
assign gpioBIn = gpioInReg[`GPM_C_BASE-1:`GPM_B_BASE];
assign padCOut = padOutReg[`GPM_D_BASE-1:`GPM_C_BASE];
assign padCOe = padOeReg[`GPM_D_BASE-1:`GPM_C_BASE];
assign gpioCIn = gpioInReg[`GPM_D_BASE-1:`GPM_C_BASE];
assign padDOut = padOutReg[ALL-1:`GPM_D_BASE];
assign padDOe = padOeReg[ALL-1:`GPM_D_BASE];
assign gpioDIn = gpioInReg[ALL-1:`GPM_D_BASE];

endmodule

// File: hdl/gpm_pin_mux_map.vh
`ifndef GPM_PIN_MUX_MAP_VH
`define GPM_PIN_MUX_MAP_VH

// physical pin positions per port (absent bits carry a slot count of zero)
`define GPM_A_PINS 12
`define GPM_B_PINS 12
`define GPM_C_PINS 13
`define GPM_D_PINS 6
`define GPM_ALL_PINS 43

// global pin index of each port's bit 0
`define GPM_B_BASE 12
`define GPM_C_BASE 24
`define GPM_D_BASE 37

// peripheral slots per pin and width of a select field
`define GPM_SLOTS 3
`define GPM_SEL_W 2
`define GPM_SLOT_FIRST 2'h0
`define GPM_NO_FUNC 2'h0

// special pins, global index
`define GPM_RESET_PIN 7
`define GPM_RESET_SLOT 0
`define GPM_CLOCK_IN_PIN_B5 17
`define GPM_CLOCK_IN_PIN_B6 18
`define GPM_CLOCK_IN_SLOT 2
`define GPM_CRYSTAL_PIN 42

// number of peripheral functions per pin, two bits per pin, pin 0 lowest
`define GPM_COUNT_A 24'h5F6F55
`define GPM_COUNT_B 24'h5ABCFA
`define GPM_COUNT_C 26'h101A6A6
`define GPM_COUNT_D 12'h955

// reset values of the function-enable bits
`define GPM_EN_RST_A 12'h080
`define GPM_EN_RST_B 12'h000
`define GPM_EN_RST_C 13'h0000
`define GPM_EN_RST_D 6'h0F
`define GPM_CRYSTAL_RST 1'b0

`endif

// File: tb/gpm_pad_model.sv
`timescale 1ns/1ns
module gpm_pad_model (
    // pad drive from the mux, global pin order
    input wire logic [42:0] padOut,
    input wire logic [42:0] padOe,
    // level the board puts on pads nobody drives
    input wire logic [42:0] extLevel,
    // level seen back at the pads
    output logic [42:0] padIn
);
    // no pulls modelled, so the board level decides every undriven pad
    assign padIn = (padOe & padOut) | (~padOe & extLevel);
endmodule

// File: tb/gpm_pin_mux_sva.sv
`timescale 1ns/1ns
module gpm_pin_mux_sva (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // configuration
    input wire logic funcEnWrite,
    input wire logic [42:0] funcEnData,
    input wire logic [42:0] funcEnState,
    input wire logic [85:0] funcSelState,
    input wire logic crystalSelState,
    input wire logic pllClockInEnable,
    // data paths
    input wire logic [128:0] altOut,
    input wire logic [128:0] altOe,
    input wire logic [128:0] altIn,
    input wire logic [11:0] gpioAOut,
    input wire logic [11:0] padAOut,
    input wire logic [11:0] padAOe,
    input wire logic [5:0] padDIn
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////
    // reset defaults, seen at the first edge after release
    a_reset_enables: assert property ($fell(rst) |-> funcEnState == 43'h1E000000080)
        else $error("enable state wrong after reset");
    a_reset_selects: assert property ($fell(rst) |-> funcSelState == 86'h0 && !crystalSelState)
        else $error("select state wrong after reset");
    // absent pins can never be handed to a peripheral
    a_enable_absent: assert property (funcEnWrite |=> funcEnState == ($past(funcEnData) & 43'h7F1FFFEFFFF))
        else $error("enable write not taken or absent pin kept");
    // reset input idles high once released to gpio, else the core would sit in reset
    a_reset_idle: assert property (!funcEnState[7] |=> altIn[21])
        else $error("reset input slot not idle high");
    a_pll_gate: assert property (!pllClockInEnable |=> altIn[53] == 1'b0 && altIn[56] == 1'b0)
        else $error("clock input passed without pll enable");
    a_timer_route: assert property (funcEnState[4] && funcSelState[9:8] == 2'h1 |=>
        padAOut[4] == $past(altOut[13]) && padAOe[4] == $past(altOe[13])) else $error("A4 timer not routed");
    a_fault_route: assert property (funcEnState[6] && funcSelState[13:12] == 2'h0 |=>
        padAOut[6] == $past(altOut[18])) else $error("A6 fault not routed");
    a_gpio_route: assert property (!funcEnState[0] |=> padAOut[0] == $past(gpioAOut[0]))
        else $error("gpio data not on pad");
    a_clock_in_d5: assert property (funcEnState[42] && crystalSelState |=> altIn[127] == $past(padDIn[5]))
        else $error("D5 clock input not routed");
    ////////////////////////////////////////////////////////////////
    // main scenarios
    c_enable_write: cover property (funcEnWrite);
    c_d5_clock: cover property (funcEnState[42] && crystalSelState);
    c_pll_off: cover property (!pllClockInEnable && funcEnState[18]);
endmodule

bind gpm_pin_mux gpm_pin_mux_sva gpm_pin_mux_sva_i (.clk(clk), .rst(rst), .funcEnWrite(funcEnWrite),
    .funcEnData(funcEnData), .funcEnState(funcEnState), .funcSelState(funcSelState),
    .crystalSelState(crystalSelState), .pllClockInEnable(pllClockInEnable), .altOut(altOut), .altOe(altOe),
    .altIn(altIn), .gpioAOut(gpioAOut), .padAOut(padAOut), .padAOe(padAOe), .padDIn(padDIn));

// File: tb/tb_top.sv
`timescale 1ns/1ns
module tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic pll = 1'b1;
    logic enW = 1'b0, selW = 1'b0, xW = 1'b0, xD = 1'b0;
    logic [42:0] enD = 43'h0, gOut = 43'h0, gOe = 43'h0, ext = 43'h0;
    logic [85:0] selD = 86'h0, sv;
    logic [128:0] altOut = 129'h0, altOe = 129'h0;
    wire [128:0] altIn;
    wire [42:0] pOut, pOe, pIn, gIn, enS;
    wire [85:0] selS;
    wire xS;
    int fails = 0, check_count = 0, cycles = 0;
    int pins[20] = '{4, 5, 6, 8, 9, 12, 13, 14, 15, 17, 18, 19, 20, 21, 24, 26, 27, 28, 30, 31};
    int cnt[20] = '{3, 3, 2, 3, 3, 2, 2, 3, 3, 3, 3, 2, 2, 2, 2, 2, 2, 2, 2, 2};
    always #5 clk = ~clk;
    ////////////////////////////////////////////////////////////////
    gpm_pin_mux gpm_pin_mux_i (.clk(clk), .rst(rst),
        .gpioAOut(gOut[11:0]), .gpioBOut(gOut[23:12]), .gpioCOut(gOut[36:24]), .gpioDOut(gOut[42:37]),
        .gpioAOe(gOe[11:0]), .gpioBOe(gOe[23:12]), .gpioCOe(gOe[36:24]), .gpioDOe(gOe[42:37]),
        .gpioAIn(gIn[11:0]), .gpioBIn(gIn[23:12]), .gpioCIn(gIn[36:24]), .gpioDIn(gIn[42:37]),
        .altOut(altOut), .altOe(altOe), .altIn(altIn),
        .padAIn(pIn[11:0]), .padBIn(pIn[23:12]), .padCIn(pIn[36:24]), .padDIn(pIn[42:37]),
        .padAOut(pOut[11:0]), .padBOut(pOut[23:12]), .padCOut(pOut[36:24]), .padDOut(pOut[42:37]),
        .padAOe(pOe[11:0]), .padBOe(pOe[23:12]), .padCOe(pOe[36:24]), .padDOe(pOe[42:37]),
        .funcEnWrite(enW), .funcEnData(enD), .funcEnState(enS),
        .funcSelWrite(selW), .funcSelData(selD), .funcSelState(selS),
        .crystalSelWrite(xW), .crystalSelData(xD), .crystalSelState(xS), .pllClockInEnable(pll));
    gpm_pad_model gpm_pad_model_i (.padOut(pOut), .padOe(pOe), .extLevel(ext), .padIn(pIn));
    ////////////////////////////////////////////////////////////////
    // compare, count and report
    task check(input logic [128:0] seen, input logic [128:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task summarize;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // one-cycle write of all three config fields, driven off the sampling edge
    task cfg(input logic [42:0] e, input logic [85:0] s, input logic x);
        @(negedge clk);
        enW = 1'b1; selW = 1'b1; xW = 1'b1; enD = e; selD = s; xD = x;
        @(negedge clk);
        enW = 1'b0; selW = 1'b0; xW = 1'b0;
        repeat (3) @(negedge clk);
    endtask
    // reset held four cycles, defaults checked while it is still applied
    task doReset;
        @(negedge clk);
        rst = 1'b1;
        repeat (4) @(negedge clk);
        check(enS, 43'h1E000000080);
        check({selS, xS}, 87'h0);
        check(altIn, 129'h200000);
        rst = 1'b0;
    endtask
    // hang guard: the whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            fails++;
            summarize();
        end
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        int k;
        doReset();
        // gpio everywhere but A7 and D0-D3; absent bits never drive
        gOut = 43'h7FFFFFFFFFF; gOe = 43'h7FFFFFFFFFF; ext = 43'h1E000000000;
        repeat (4) @(negedge clk);
        check(pOut & pOe, 43'h611FFFEFF7F);
        // port logic reads the pad in peripheral mode too, so the test-port pins show the board level
        check(gIn, 43'h7F1FFFEFF7F);
        check(altIn[23:21], 3'h0);
        check(altIn[120:111], 10'h249);
        gOut = 43'h0; gOe = 43'h0; ext = 43'h0;
        // every select value on every muxed pin except D5, out-of-range values fall back to slot 0
        for (int i = 0; i < 20; i++) begin
            for (int s = 0; s < 4; s++) begin
                k = (s < cnt[i]) ? s : 0;
                sv = 86'h0;
                sv[2*pins[i] +: 2] = s[1:0];
                altOut = 129'h1 << (3 * pins[i] + k);
                altOe = altOut;
                cfg(43'h1 << pins[i], sv, 1'b0);
                check(pOut[pins[i]] & pOe[pins[i]], 1'b1);
                check(altIn[3*pins[i] +: 3], 3'h1 << k);
            end
        end
        // D5 crystal output, then clock input with the pll gate off
        altOut = 129'h1 << 126; altOe = altOut;
        cfg(43'h1 << 42, 86'h0, 1'b0);
        check(pOut[42] & pOe[42], 1'b1);
        altOe = 129'h0; ext = 43'h1 << 42; pll = 1'b0;
        cfg(43'h1 << 42, 86'h0, 1'b1);
        check(altIn[128:126], 3'h2);
        // B6 clock input blocked until the pll enable comes on
        sv = 86'h0; sv[37:36] = 2'h2; ext = 43'h1 << 18;
        cfg(43'h1 << 18, sv, 1'b0);
        check(altIn[56:54], 3'h0);
        pll = 1'b1;
        repeat (3) @(negedge clk);
        check(altIn[56:54], 3'h4);
        // all-ones enable write keeps absent pins out, then a mid-run reset
        cfg(43'h7FFFFFFFFFF, 86'h0, 1'b0);
        check(enS, 43'h7F1FFFEFFFF);
        doReset();
        // defaults must survive the first edges after a mid-run release
        repeat (2) @(negedge clk);
        check(enS, 43'h1E000000080);
        summarize();
    end
endmodule
